// ---- hw/fbpp_pkg.sv ----
// Shared constants, register map and types of the frame buffer pixel packer.
package fbpp_pkg;

	// Register byte offsets on the APB bus.
	localparam logic [7:0] FBPP_OFS_CTRL = 8'h00;
	localparam logic [7:0] FBPP_OFS_FILL = 8'h04;
	localparam logic [7:0] FBPP_OFS_OVF = 8'h08;
	localparam logic [7:0] FBPP_OFS_INFO = 8'h0C;

	// Control register fields.
	localparam int FBPP_CTRL_FMT_LSB = 0;
	localparam int FBPP_CTRL_FMT_W = 3;
	localparam int FBPP_CTRL_ALIGN_LSB = 4;
	localparam int FBPP_CTRL_ALIGN_W = 2;
	localparam int FBPP_CTRL_SHIFT_LSB = 8;
	localparam int FBPP_CTRL_SHIFT_W = 4;
	localparam int FBPP_CTRL_CAMW_LSB = 12;
	localparam int FBPP_CTRL_CAMW_W = 3;
	localparam logic [31:0] FBPP_CTRL_RESET = 32'h0000_3000;
	localparam logic [31:0] FBPP_CTRL_MASK = 32'h0000_7F37;

	// Information register fields.
	localparam int FBPP_INFO_FMT_LSB = 0;
	localparam int FBPP_INFO_BPP_LSB = 8;

	// Sample widths and scales.
	localparam int FBPP_INT_W = 14;
	localparam int FBPP_LANE_W = 16;
	localparam int FBPP_LANES = 3;
	localparam int FBPP_WORD_W = 32;
	localparam int FBPP_ACC_W = 96;
	localparam logic [6:0] FBPP_FILL_SCALE = 7'h64;
	localparam int FBPP_FIFO_DEPTH = 64;

	// Output format codes.
	localparam logic [2:0] FBPP_GRAY_8BIT = 3'h0;
	localparam logic [2:0] FBPP_GRAY_10BIT_PACKED = 3'h1;
	localparam logic [2:0] FBPP_GRAY_12BIT_PACKED = 3'h2;
	localparam logic [2:0] FBPP_COLOUR_24BIT = 3'h3;
	localparam logic [2:0] FBPP_COLOUR_30BIT_PACKED = 3'h4;
	localparam logic [2:0] FBPP_COLOUR_36BIT_PACKED = 3'h5;
	localparam logic [2:0] FBPP_COLOUR_48BIT = 3'h6;

	// Output bit placement modes.
	localparam logic [1:0] FBPP_PLACE_MSB = 2'h0;
	localparam logic [1:0] FBPP_PLACE_LSB = 2'h1;
	localparam logic [1:0] FBPP_PLACE_SHIFT = 2'h2;

	typedef enum logic [0:0] {
		FBPP_PK_RUN = 1'b0,
		FBPP_PK_FLUSH = 1'b1
	} fbpp_pk_state_t;

	// Bits per component of an output format.
	function automatic logic [4:0] fbpp_comp_width(input logic [2:0] fmt);
		case (fmt)
			FBPP_GRAY_10BIT_PACKED, FBPP_COLOUR_30BIT_PACKED: return 5'h0A;
			FBPP_GRAY_12BIT_PACKED, FBPP_COLOUR_36BIT_PACKED: return 5'h0C;
			FBPP_COLOUR_48BIT: return 5'h10;
			default: return 5'h08;
		endcase
	endfunction

	// Bits per camera component: codes 0..4 give 8, 10, 12, 14, 16.
	function automatic logic [4:0] fbpp_cam_width(input logic [2:0] code);
		case (code)
			3'h1: return 5'h0A;
			3'h2: return 5'h0C;
			3'h3: return 5'h0E;
			3'h4: return 5'h10;
			default: return 5'h08;
		endcase
	endfunction

endpackage

// ---- hw/fbpp_frame_fifo.sv ----
// Frame buffer storage: a flip-flop FIFO with an occupancy count.
`timescale 1ns/1ps
`default_nettype none
module fbpp_frame_fifo #(
	parameter int WIDTH = 43,
	parameter int DEPTH = 64,
	parameter int CW = $clog2(DEPTH + 1)
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic wrEn,
	input wire logic [WIDTH-1:0] wrData,
	output logic full,
	input wire logic rdEn,
	output logic [WIDTH-1:0] rdData,
	output logic empty,
	output logic [CW-1:0] count
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wrPtr_reg;
	logic [AW-1:0] rdPtr_reg;
	logic [CW-1:0] count_reg;
	logic doWr;
	logic doRd;

	assign doWr = wrEn & ~full;
	assign doRd = rdEn & ~empty;
	assign full = (count_reg == CW'(DEPTH));
	assign empty = (count_reg == '0);
	assign count = count_reg;
	assign rdData = mem_reg[rdPtr_reg];

	always_ff @(posedge clk) begin
		if (doWr) begin
			mem_reg[wrPtr_reg] <= wrData;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (doWr) begin
				wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
			end
			if (doRd) begin
				rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
			end
			count_reg <= count_reg + CW'(doWr) - CW'(doRd);
		end
	end
endmodule // fbpp_frame_fifo
`default_nettype wire

// ---- hw/fbpp_bit_aligner.sv ----
// Selects which internal sample bits reach one output component.
`timescale 1ns/1ps
`default_nettype none
module fbpp_bit_aligner
	import fbpp_pkg::*;
(
	input wire logic [FBPP_INT_W-1:0] sample,
	input wire logic [4:0] compWidth,
	input wire logic [1:0] placement,
	input wire logic [3:0] shiftRight,
	output logic [FBPP_LANE_W-1:0] comp
);
	logic [FBPP_LANE_W-1:0] wide;
	logic [FBPP_LANE_W:0] maskFull;
	logic [FBPP_LANE_W-1:0] msbAligned;
	logic [FBPP_LANE_W-1:0] selected;

	assign wide = FBPP_LANE_W'(sample);
	assign maskFull = (17'h0_0001 << compWidth) - 17'h0_0001;
	// Most significant internal bits land on the output's top bits.
	assign msbAligned = (compWidth >= 5'h0E) ?
		(wide << (compWidth - 5'h0E)) : (wide >> (5'h0E - compWidth));
	assign selected = (placement == FBPP_PLACE_LSB) ? wide :
		(placement == FBPP_PLACE_SHIFT) ? (wide >> shiftRight) : msbAligned;
	assign comp = selected & maskFull[FBPP_LANE_W-1:0];
endmodule // fbpp_bit_aligner
`default_nettype wire

// ---- hw/fbpp_frame_packer.sv ----
// Frame buffer with fill level, overflow flag and DMA pixel packer.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Buffer occupancy reads as an integer percentage from 0 to 100.
// - At full capacity, further camera words are discarded.
// - Overflow flag is one bit: 1 after an overflow, else 0.
// - Each software read of the overflow flag clears it.
// - Processing holds one line's bits at a time; the buffer absorbs jitter.
// - No event or interrupt on overflow; polling is the only indication.
// - Every camera component is mapped to a 14-bit internal sample.
// - Colour outputs of 24, 30, 36 and 48 bits are offered.
// - Grayscale outputs of 8, 10 and 12 bits are offered, packed.
// - 30-bit colour packs components contiguously: eight in ten bytes.
// - 36-bit colour packs two components in three bytes.
// - Components go blue, green, red from low to high address.
// - 10-bit gray packs eight pixels into ten bytes.
// - Padding bytes after the last pixel are undefined; receiver ignores them.
// - Bit placement setting chooses which internal bits reach the output.
// - Selected format drives the pixel format info given to the consumer.
// - 12-bit gray packs two pixels into three bytes.
module fbpp_frame_packer
	import fbpp_pkg::*;
#(
	parameter int DEPTH = FBPP_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic camValid,
	input wire logic [FBPP_LANES*FBPP_LANE_W-1:0] camData,
	input wire logic camLast,
	output logic dmaValid,
	output logic [FBPP_WORD_W-1:0] dmaData,
	output logic dmaLast,
	input wire logic dmaReady,
	output logic [2:0] pixelFormatCode,
	output logic [5:0] bitsPerPixel
);
	localparam int CW = $clog2(DEPTH + 1);
	localparam int EW = FBPP_LANES * FBPP_INT_W + 1;
	localparam int PW = FBPP_CTRL_FMT_W + 7;

	// Register state.
	logic [31:0] ctrl_reg;
	logic [6:0] fillPct_reg;
	logic overflow_reg;
	logic ovfSeen_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;

	// Packer state.
	fbpp_pk_state_t pkState_reg;
	fbpp_pk_state_t pkState_next;
	logic [FBPP_ACC_W-1:0] acc_reg;
	logic [FBPP_ACC_W-1:0] acc_next;
	logic [6:0] accBits_reg;
	logic [6:0] accBits_next;
	logic dmaValid_reg;
	logic [FBPP_WORD_W-1:0] dmaData_reg;
	logic dmaLast_reg;
	logic [2:0] fmtInfo_reg;
	logic [5:0] bppInfo_reg;

	// Control fields.
	logic [2:0] fmtSel;
	logic [1:0] placeSel;
	logic [3:0] shiftSel;
	logic [2:0] camWidthCode;
	logic [4:0] camWidth;
	logic [4:0] compWidth;
	logic isColour;
	logic [5:0] bppNow;

	assign fmtSel = ctrl_reg[FBPP_CTRL_FMT_LSB +: FBPP_CTRL_FMT_W];
	assign placeSel = ctrl_reg[FBPP_CTRL_ALIGN_LSB +: FBPP_CTRL_ALIGN_W];
	assign shiftSel = ctrl_reg[FBPP_CTRL_SHIFT_LSB +: FBPP_CTRL_SHIFT_W];
	assign camWidthCode = ctrl_reg[FBPP_CTRL_CAMW_LSB +: FBPP_CTRL_CAMW_W];
	assign camWidth = fbpp_cam_width(camWidthCode);
	assign compWidth = fbpp_comp_width(fmtSel);
	assign isColour = (fmtSel >= FBPP_COLOUR_24BIT) &&
		(fmtSel <= FBPP_COLOUR_48BIT);
	assign bppNow = isColour ? 6'(3 * compWidth) : 6'(compWidth);

	// APB decode. The slave answers in the first access cycle.
	logic apbSetup;
	logic apbAccess;
	logic hitCtrl;
	logic hitFill;
	logic hitOvf;
	logic hitInfo;
	logic addrHit;
	logic ctrlWrite;
	logic ovfReadClear;
	logic [31:0] readMux;

	assign apbSetup = psel & ~penable;
	assign apbAccess = psel & penable & pready_reg;
	assign hitCtrl = (paddr == FBPP_OFS_CTRL);
	assign hitFill = (paddr == FBPP_OFS_FILL);
	assign hitOvf = (paddr == FBPP_OFS_OVF);
	assign hitInfo = (paddr == FBPP_OFS_INFO);
	assign addrHit = hitCtrl | hitFill | hitOvf | hitInfo;
	assign ctrlWrite = apbAccess & pwrite & hitCtrl;
	// Only a flag that was actually returned to software is cleared.
	assign ovfReadClear = apbAccess & ~pwrite & hitOvf & ovfSeen_reg;
	assign readMux = hitCtrl ? (ctrl_reg & FBPP_CTRL_MASK) :
		hitFill ? {25'h000_0000, fillPct_reg} :
		hitOvf ? {31'h0000_0000, overflow_reg} :
		hitInfo ? ({26'h000_0000, bppInfo_reg} << FBPP_INFO_BPP_LSB) |
			({29'h0000_0000, fmtInfo_reg} << FBPP_INFO_FMT_LSB) :
		32'h0000_0000;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= FBPP_CTRL_RESET;
		end else if (ctrlWrite) begin
			ctrl_reg <= pwdata & FBPP_CTRL_MASK;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			ovfSeen_reg <= 1'b0;
		end else begin
			pready_reg <= apbSetup;
			pslverr_reg <= apbSetup & ~addrHit;
			if (apbSetup) begin
				prdata_reg <= pwrite ? 32'h0000_0000 : readMux;
				ovfSeen_reg <= overflow_reg & ~pwrite & hitOvf;
			end
		end
	end

	// Camera lanes mapped onto the internal sample width.
	logic [FBPP_INT_W-1:0] sample [FBPP_LANES];
	logic [FBPP_LANE_W-1:0] comp [FBPP_LANES];
	logic [FBPP_LANES*FBPP_INT_W-1:0] mappedWord;
	logic [FBPP_LANES*FBPP_INT_W-1:0] storedWord;

	genvar lane;
	generate
		for (lane = 0; lane < FBPP_LANES; lane++) begin : gLane
			logic [FBPP_LANE_W-1:0] raw;
			assign raw = camData[lane*FBPP_LANE_W +: FBPP_LANE_W];
			assign mappedWord[lane*FBPP_INT_W +: FBPP_INT_W] =
				(camWidth < 5'h0E) ?
				FBPP_INT_W'(raw << (5'h0E - camWidth)) :
				FBPP_INT_W'(raw >> (camWidth - 5'h0E));
			assign sample[lane] = storedWord[lane*FBPP_INT_W +: FBPP_INT_W];
			fbpp_bit_aligner uAlign (
				.sample(sample[lane]),
				.compWidth(compWidth),
				.placement(placeSel),
				.shiftRight(shiftSel),
				.comp(comp[lane])
			);
		end
	endgenerate

	// Frame buffer between the camera and the packer.
	logic fifoFull;
	logic fifoEmpty;
	logic fifoRead;
	logic [EW-1:0] fifoOut;
	logic [CW-1:0] fifoCount;
	logic camDiscard;
	logic entryLast;

	assign camDiscard = camValid & fifoFull;
	assign storedWord = fifoOut[EW-1:1];
	assign entryLast = fifoOut[0];

	fbpp_frame_fifo #(
		.WIDTH(EW),
		.DEPTH(DEPTH),
		.CW(CW)
	) uBuffer (
		.clk(clk),
		.arst_n(arst_n),
		.wrEn(camValid),
		.wrData({mappedWord, camLast}),
		.full(fifoFull),
		.rdEn(fifoRead),
		.rdData(fifoOut),
		.empty(fifoEmpty),
		.count(fifoCount)
	);

	// Fill level in whole percent, refreshed every cycle.
	logic [CW+PW-1:0] fillProduct;
	logic [6:0] fillPctNext;

	assign fillProduct = (CW+PW)'(fifoCount) * (CW+PW)'(FBPP_FILL_SCALE);
	assign fillPctNext = 7'(fillProduct / (CW+PW)'(DEPTH));

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fillPct_reg <= 7'h00;
		end else begin
			fillPct_reg <= fillPctNext;
		end
	end

	// A new discard wins over a clear in the same cycle. The flag drives no
	// interrupt; software has to poll it.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			overflow_reg <= 1'b0;
		end else begin
			overflow_reg <= camDiscard | (overflow_reg & ~ovfReadClear);
		end
	end

	// Pixel assembled blue in the low bits, then green, then red.
	logic [47:0] pixBits;
	logic [47:0] colourBits;

	assign colourBits = 48'(comp[0]) |
		(48'(comp[1]) << compWidth) |
		(48'(comp[2]) << (6'(compWidth) << 1));
	assign pixBits = isColour ? colourBits : 48'(comp[0]);

	// Packer: bits accumulate LSB first and leave as 32-bit words.
	logic outFree;
	logic flushing;
	logic haveWord;
	logic emit;
	logic emitLast;
	logic [6:0] remBits;
	logic [FBPP_ACC_W-1:0] accShifted;
	logic [FBPP_ACC_W-1:0] pixPlaced;

	assign outFree = ~dmaValid_reg | dmaReady;
	assign flushing = (pkState_reg == FBPP_PK_FLUSH);
	assign haveWord = (accBits_reg >= 7'h20);
	assign emit = outFree & (haveWord | (flushing & (accBits_reg != 7'h00)));
	// The final word of a line is padded with zeros above the last pixel.
	assign emitLast = emit & flushing & (accBits_reg <= 7'h20);
	assign remBits = !emit ? accBits_reg :
		haveWord ? (accBits_reg - 7'h20) : 7'h00;
	assign fifoRead = ~fifoEmpty & ~flushing & (remBits < 7'h20);
	assign accShifted = emit ? (acc_reg >> FBPP_WORD_W) : acc_reg;
	assign pixPlaced = FBPP_ACC_W'(pixBits) << remBits;

	always_comb begin
		acc_next = accShifted | (fifoRead ? pixPlaced : '0);
		accBits_next = remBits + (fifoRead ? 7'(bppNow) : 7'h00);
		pkState_next = pkState_reg;
		if (fifoRead && entryLast) begin
			pkState_next = FBPP_PK_FLUSH;
		end
		if (emitLast || (flushing && accBits_reg == 7'h00)) begin
			acc_next = '0;
			accBits_next = 7'h00;
			pkState_next = FBPP_PK_RUN;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_reg <= '0;
			accBits_reg <= 7'h00;
			pkState_reg <= FBPP_PK_RUN;
		end else begin
			acc_reg <= acc_next;
			accBits_reg <= accBits_next;
			pkState_reg <= pkState_next;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dmaValid_reg <= 1'b0;
			dmaData_reg <= 32'h0000_0000;
			dmaLast_reg <= 1'b0;
		end else if (emit) begin
			dmaValid_reg <= 1'b1;
			dmaData_reg <= acc_reg[FBPP_WORD_W-1:0];
			dmaLast_reg <= emitLast;
		end else if (dmaReady) begin
			dmaValid_reg <= 1'b0;
			dmaLast_reg <= 1'b0;
		end
	end

	// Format information reported with the delivered buffers.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fmtInfo_reg <= FBPP_GRAY_8BIT;
			bppInfo_reg <= 6'h00;
		end else begin
			fmtInfo_reg <= fmtSel;
			bppInfo_reg <= bppNow;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign dmaValid = dmaValid_reg;
	assign dmaData = dmaData_reg;
	assign dmaLast = dmaLast_reg;
	assign pixelFormatCode = fmtInfo_reg;
	assign bitsPerPixel = bppInfo_reg;
endmodule // fbpp_frame_packer
`default_nettype wire

// ---- tb/fbpp_frame_packer_asserts.sv ----
// Concurrent checks on the ports of the frame buffer pixel packer.
`timescale 1ns/1ps
`default_nettype none
module fbpp_frame_packer_asserts
	import fbpp_pkg::*;
#(
	parameter int DEPTH = FBPP_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic camValid,
	input wire logic [FBPP_LANES*FBPP_LANE_W-1:0] camData,
	input wire logic camLast,
	input wire logic dmaValid,
	input wire logic [FBPP_WORD_W-1:0] dmaData,
	input wire logic dmaLast,
	input wire logic dmaReady,
	input wire logic [2:0] pixelFormatCode,
	input wire logic [5:0] bitsPerPixel
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	logic sawCam_reg;
	logic [5:0] bppExp;
	wire rdAcc = psel && penable && pready && !pwrite;
	wire rdFill = rdAcc && paddr == FBPP_OFS_FILL;
	wire rdOvf = rdAcc && paddr == FBPP_OFS_OVF;
	wire rdInfo = rdAcc && paddr == FBPP_OFS_INFO;
	wire setupOvf = psel && !penable && !pwrite && paddr == FBPP_OFS_OVF;
	assign bppExp = (pixelFormatCode == FBPP_GRAY_10BIT_PACKED) ? 6'h0A :
		(pixelFormatCode == FBPP_GRAY_12BIT_PACKED) ? 6'h0C :
		(pixelFormatCode == FBPP_COLOUR_24BIT) ? 6'h18 :
		(pixelFormatCode == FBPP_COLOUR_30BIT_PACKED) ? 6'h1E :
		(pixelFormatCode == FBPP_COLOUR_36BIT_PACKED) ? 6'h24 :
		(pixelFormatCode == FBPP_COLOUR_48BIT) ? 6'h30 : 6'h08;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sawCam_reg <= 1'b0;
		end else if (camValid) begin
			sawCam_reg <= 1'b1;
		end
	end
	a_fill_range: assert property (rdFill |-> prdata <= 32'h0000_0064)
		else $error("fill level outside 0 to 100");
	a_fill_empty: assert property (
		rdFill && !sawCam_reg |-> prdata == 32'h0000_0000)
		else $error("fill level not 0 before any pixel");
	a_ovf_bit: assert property (rdOvf |-> prdata[31:1] == 31'h0000_0000)
		else $error("overflow read wider than one bit");
	a_ovf_quiet: assert property (
		rdOvf && !sawCam_reg |-> prdata[0] == 1'b0)
		else $error("overflow set without any pixel");
	a_ovf_clear: assert property (
		rdOvf && prdata[0] && !camValid ##1 setupOvf && !camValid
		|=> prdata[0] == 1'b0)
		else $error("overflow not cleared by read");
	a_info_bpp: assert property (
		$past(arst_n) && $stable(pixelFormatCode) |-> bitsPerPixel == bppExp)
		else $error("bits per pixel wrong for format");
	a_info_read: assert property (rdInfo |-> prdata[2:0] == pixelFormatCode
		&& prdata[13:8] == bitsPerPixel)
		else $error("info read disagrees with format outputs");
	a_dma_hold: assert property (dmaValid && !dmaReady |=> dmaValid
		&& $stable(dmaData) && $stable(dmaLast))
		else $error("output word changed before taken");
endmodule // fbpp_frame_packer_asserts
bind fbpp_frame_packer fbpp_frame_packer_asserts #(.DEPTH(DEPTH))
	fbpp_frame_packer_asserts_inst (.clk, .arst_n, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .camValid, .camData,
	.camLast, .dmaValid, .dmaData, .dmaLast, .dmaReady, .pixelFormatCode,
	.bitsPerPixel);
`default_nettype wire

// ---- tb/fbpp_dma_sink.sv ----
// DMA channel model that takes packed words into a capture array.
`timescale 1ns/1ps
`default_nettype none
module fbpp_dma_sink (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic dmaValid,
	input wire logic [31:0] dmaData,
	input wire logic dmaLast,
	input wire logic stall,
	input wire logic slow,
	input wire logic clear,
	output logic dmaReady
);
	logic [31:0] words [0:15];
	int count;
	logic gotLast;
	logic phase;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dmaReady <= 1'b0;
			phase <= 1'b0;
			count <= 0;
			gotLast <= 1'b0;
		end else begin
			phase <= !phase;
			dmaReady <= !stall && (!slow || phase);
			if (clear) begin
				count <= 0;
				gotLast <= 1'b0;
			end else if (dmaValid && dmaReady) begin
				// Padding is stored raw; the reader masks it off.
				words[count[3:0]] <= dmaData;
				count <= count + 1;
				gotLast <= dmaLast;
			end
		end
	end
endmodule // fbpp_dma_sink
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking testbench of the frame buffer pixel packer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import fbpp_pkg::*;
	localparam int DEPTH = 4;
	logic clk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, dmaData;
	logic camValid, camLast, dmaValid, dmaLast, dmaReady, stall, slow, clear;
	logic [47:0] camData;
	logic [2:0] pixelFormatCode;
	logic [5:0] bitsPerPixel;
	int fails, checks;
	fbpp_frame_packer #(.DEPTH(DEPTH)) fbpp_frame_packer_inst (.clk, .arst_n,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.camValid, .camData, .camLast, .dmaValid, .dmaData, .dmaLast,
		.dmaReady, .pixelFormatCode, .bitsPerPixel);
	fbpp_dma_sink fbpp_dma_sink_inst (.clk, .arst_n, .dmaValid, .dmaData,
		.dmaLast, .stall, .slow, .clear, .dmaReady);
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, exp, input string what);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: %s got %h wanted %h", $time, what, got, exp);
		end
	endtask
	// Leaves the bus in its access phase so another setup may follow at once.
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		e = pslverr;
	endtask
	task automatic idle(input int n);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (n) @(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		check(r, exp, "register read");
	endtask
	task automatic waitLast();
		for (int k = 0; k < 400 && !fbpp_dma_sink_inst.gotLast; k++)
			@(posedge clk);
	endtask
	task automatic testRegs();
		logic [31:0] r;
		logic e;
		rd(FBPP_OFS_CTRL, FBPP_CTRL_RESET);
		rd(FBPP_OFS_FILL, 32'h0000_0000);
		rd(FBPP_OFS_OVF, 32'h0000_0000);
		rd(FBPP_OFS_INFO, 32'h0000_0800);
		apb(1'b1, FBPP_OFS_FILL, 32'h0000_0055, r, e);
		rd(FBPP_OFS_FILL, 32'h0000_0000);
		apb(1'b0, 8'h10, 32'h0000_0000, r, e);
		check({31'h0000_0000, e}, 32'h0000_0001, "unmapped error");
		idle(1);
	endtask
	task automatic runFormat(input logic [2:0] fmt, camw, input logic [1:0] pl,
		input logic [15:0] hi, input int nc, w);
		logic [383:0] bits;
		logic [47:0] px;
		logic [15:0] v;
		logic [31:0] r, m;
		logic e;
		int pos, nw;
		bits = '0;
		pos = 0;
		clear <= 1'b1;
		slow <= fmt[0];
		apb(1'b1, FBPP_OFS_CTRL, (32'(camw) << FBPP_CTRL_CAMW_LSB) |
			(32'(pl) << FBPP_CTRL_ALIGN_LSB) | 32'(fmt), r, e);
		clear <= 1'b0;
		idle(2);
		rd(FBPP_OFS_INFO, (32'(nc * w) << FBPP_INFO_BPP_LSB) | 32'(fmt));
		idle(1);
		for (int i = 0; i < 8; i++) begin
			px = '0;
			for (int c = 0; c < nc; c++) begin
				v = 16'hA5C3 ^ 16'(i * 16'h1357 + c * 16'h0F0F);
				v = v & ((16'h0001 << w) - 16'h0001);
				if (w == 16) v[1:0] = 2'b00;
				px[c*16 +: 16] = v | hi;
				for (int b = 0; b < w; b++) bits[pos + b] = v[b];
				pos += w;
			end
			camValid <= 1'b1;
			camData <= px;
			camLast <= (i == 7);
			@(posedge clk);
		end
		camValid <= 1'b0;
		camLast <= 1'b0;
		waitLast();
		nw = (pos + 31) / 32;
		check(fbpp_dma_sink_inst.count, nw, "word count");
		for (int k = 0; k < nw; k++) begin
			m = 32'hFFFF_FFFF;
			if (k == nw - 1 && pos % 32 != 0) m = m >> (32 - pos % 32);
			check(fbpp_dma_sink_inst.words[k] & m, bits[k*32 +: 32] & m,
				"packed word");
		end
	endtask
	task automatic testOverflow();
		logic [31:0] r;
		logic e;
		clear <= 1'b1;
		stall <= 1'b1;
		apb(1'b1, FBPP_OFS_CTRL, 32'h0000_0000, r, e);
		clear <= 1'b0;
		idle(1);
		for (int i = 0; i < 40; i++) begin
			camValid <= 1'b1;
			camData <= 48'(i);
			@(posedge clk);
		end
		camValid <= 1'b0;
		rd(FBPP_OFS_FILL, 32'h0000_0064);
		rd(FBPP_OFS_OVF, 32'h0000_0001);
		rd(FBPP_OFS_OVF, 32'h0000_0000);
		idle(1);
		stall <= 1'b0;
		// The buffer must drain before the closing pixel, or it is dropped.
		idle(8);
		camValid <= 1'b1;
		camLast <= 1'b1;
		@(posedge clk);
		camValid <= 1'b0;
		camLast <= 1'b0;
		waitLast();
		rd(FBPP_OFS_FILL, 32'h0000_0000);
		rd(FBPP_OFS_OVF, 32'h0000_0000);
		idle(1);
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		conclude();
	end
	initial begin
		{arst_n, psel, penable, pwrite, camValid, camLast} = '0;
		{stall, slow, clear} = '0;
		paddr = 8'h00;
		pwdata = '0;
		camData = '0;
		fails = 0;
		checks = 0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		testRegs();
		runFormat(FBPP_GRAY_8BIT, 3'h0, FBPP_PLACE_MSB, 16'h0000, 1, 8);
		runFormat(FBPP_GRAY_10BIT_PACKED, 3'h1, 2'h0, 16'h0000, 1, 10);
		runFormat(FBPP_GRAY_12BIT_PACKED, 3'h2, 2'h0, 16'h0000, 1, 12);
		runFormat(FBPP_COLOUR_24BIT, 3'h0, 2'h0, 16'h0000, 3, 8);
		runFormat(FBPP_COLOUR_30BIT_PACKED, 3'h1, 2'h0, 16'h0000, 3, 10);
		runFormat(FBPP_COLOUR_36BIT_PACKED, 3'h2, 2'h0, 16'h0000, 3, 12);
		runFormat(FBPP_COLOUR_48BIT, 3'h4, 2'h0, 16'h0000, 3, 16);
		runFormat(FBPP_GRAY_8BIT, 3'h3, FBPP_PLACE_LSB, 16'h3F00, 1, 8);
		testOverflow();
		conclude();
	end
endmodule // testbench
`default_nettype wire
